// file: verilog/eeprom_prog_pkg.sv
// Purpose: Shared constants and types of the serial config EEPROM port
// Assumes: 25 MHz system clock
// Notes:   Timing counts derive from printed times and the clock period
package eeprom_prog_pkg;

  // ------------------------------------------------------------
  // Clock and timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int TWR_MS        = 20;                  // Write cycle time
  localparam int TWR_CYCLES    = TWR_MS * 1_000_000 / CLK_PERIOD_NS;
  localparam int TWR_W         = 20;

  // ------------------------------------------------------------
  // Array and framing
  // ------------------------------------------------------------
  localparam int ADDR_W                  = 15;
  localparam int PAGE_W                  = 6;
  localparam logic [3:0]        DEV_ID    = 4'hA;     // Fixed 1,0,1,0
  localparam logic [1:0]        DEV_FIX   = 2'h3;     // Fixed 1,1
  localparam logic [3:0]        BYTE_BITS = 4'h8;
  localparam logic [2:0]        LAST_BIT  = 3'h7;
  localparam logic [ADDR_W-1:0] POL_ADDR  = 15'h3FFF; // Polarity option
  localparam logic [7:0]        POL_HI    = 8'hFF;    // Active-high code
  localparam logic [ADDR_W-1:0] CFG_LAST  = 15'h7FFF; // Last config byte
  localparam logic              POL_RESET = 1'h0;     // Active low at reset

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_DEV, ST_AHI, ST_ALO, ST_WDAT, ST_RDAT, ST_RACK
  } state_e;

  typedef struct packed {
    logic scl;
    logic sda;
    logic ce_n;
    logic roe;
    logic spe_n;
    logic sel;
  } pins_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
  } wr_req_s;

endpackage : eeprom_prog_pkg

// file: verilog/wr_fifo.sv
// Purpose: Small synchronous FIFO for array write requests
// Assumes: DEPTH is a power of two
// Notes:   Full and empty come from pointers with a wrap bit
`timescale 1ns/100ps
module wr_fifo #(
  parameter int W     = 23,
  parameter int DEPTH = 4
) (
  input  wire logic         clk_sys_in,
  input  wire logic         arst_n_in,
  input  wire logic         in_valid_in,
  output logic              in_ready_out,
  input  wire logic [W-1:0] in_data_in,
  output logic              out_valid_out,
  input  wire logic         out_ready_in,
  output logic [W-1:0]      out_data_out
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW:0]             wp;
    logic [AW:0]             rp;
  } fifo_s;

  fifo_s r_r;
  fifo_s r_nxt;
  logic  full;
  logic  empty;

  // Flags from pointer compare
  assign empty         = (r_r.wp == r_r.rp);
  assign full          = (r_r.wp[AW] != r_r.rp[AW]) &&
                         (r_r.wp[AW-1:0] == r_r.rp[AW-1:0]);
  assign in_ready_out  = !full;
  assign out_valid_out = !empty;
  assign out_data_out  = r_r.mem[r_r.rp[AW-1:0]];

  // Push and pop
  always_comb
  begin
    r_nxt = r_r;
    if (in_valid_in && !full)
    begin
      r_nxt.mem[r_r.wp[AW-1:0]] = in_data_in;
      r_nxt.wp = r_r.wp + 1'b1;
    end
    if (out_ready_in && !empty)
      r_nxt.rp = r_r.rp + 1'b1;
  end

  // State register
  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      r_r <= '0;
    else
      r_r <= r_nxt;
  end

endmodule : wr_fifo

// file: verilog/serial_config_eeprom_prog_port.sv
// Purpose: Two-wire programming port and config stream of a serial EEPROM
// Assumes: Array lives outside; read data valid one cycle after address
// Notes:   Link clock and all pins are sampled through two flip-flops
`timescale 1ns/100ps
module serial_config_eeprom_prog_port
  import eeprom_prog_pkg::*;
#(
  parameter logic [TWR_W-1:0]  TWR_CYC    = TWR_W'(TWR_CYCLES),
  parameter logic [ADDR_W-1:0] LAST_ADDR  = CFG_LAST,
  parameter int                FIFO_DEPTH = 4
) (
  input  wire logic                         clk_sys_in,
  input  wire logic                         arst_n_in,
  input  wire logic                         scl_in,
  input  wire logic                         sda_in,
  output logic                              sda_out,
  output logic                              sda_oe_out,
  input  wire logic                         ce_n_in,
  input  wire logic                         reset_oe_in,
  input  wire logic                         serial_program_enable_n_in,
  input  wire logic                         cascade_enable_in,
  output logic                              cascade_enable_out,
  output logic                              cascade_enable_oe_out,
  output logic [eeprom_prog_pkg::ADDR_W-1:0] mem_rd_addr_out,
  input  wire logic [7:0]                   mem_rd_data_in,
  output logic                              mem_wr_valid_out,
  input  wire logic                         mem_wr_ready_in,
  output eeprom_prog_pkg::wr_req_s          mem_wr_out,
  output logic                              write_busy_out,
  output logic                              reset_polarity_high_out
);
  import eeprom_prog_pkg::*;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    pins_s             s1;
    pins_s             s2;
    logic              scl_q;
    logic              sda_q;
    state_e            st;
    logic [3:0]        cnt;
    logic              ack;
    logic              ack_drv;
    logic              hack;
    logic [7:0]        sh;
    logic [7:0]        tx;
    logic [ADDR_W-1:0] addr;
    logic              wrote;
    logic [TWR_W-1:0]  wtimer;
    logic [ADDR_W-1:0] caddr;
    logic [2:0]        cbit;
    logic              done;
    logic              pol_hi;
    logic [ADDR_W-1:0] rdaddr;
    logic              sda_o;
    logic              sda_oe;
    logic              ceo_o;
    logic              ceo_oe;
  } state_s;

  state_s  r_r;
  state_s  r_nxt;
  pins_s   pins;
  logic    rise;
  logic    fall;
  logic    start;
  logic    stop;
  logic    prog;
  logic    rst_act;
  logic    ce_act;
  logic    push;
  logic    push_ready;
  logic    fifo_busy;
  logic    dev_ok;
  wr_req_s wreq;

  // ------------------------------------------------------------
  // Pin sampling and line events
  // ------------------------------------------------------------
  assign pins  = '{scl: scl_in, sda: sda_in, ce_n: ce_n_in,
                   roe: reset_oe_in, spe_n: serial_program_enable_n_in,
                   sel: cascade_enable_in};
  assign rise  = r_r.s2.scl && !r_r.scl_q;
  assign fall  = !r_r.s2.scl && r_r.scl_q;
  // Data edges count only while clock stays high
  assign start = r_r.scl_q && r_r.s2.scl && r_r.sda_q && !r_r.s2.sda;
  assign stop  = r_r.scl_q && r_r.s2.scl && !r_r.sda_q && r_r.s2.sda;
  assign prog  = !r_r.s2.spe_n;
  // Reset/OE meaning follows the stored polarity option
  assign rst_act = r_r.pol_hi ? r_r.s2.roe : !r_r.s2.roe;
  assign ce_act  = !r_r.s2.ce_n;
  // Device address match: fixed bits, select bit, no write in progress
  assign dev_ok  = (r_r.sh[7:4] == DEV_ID) && (r_r.sh[2:1] == DEV_FIX)
                   && (r_r.sh[3] == r_r.s2.sel)
                   && (r_r.wtimer == '0) && !fifo_busy;
  assign wreq    = '{addr: r_r.addr, data: r_r.sh};

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb
  begin
    r_nxt = r_r;
    push  = 1'b0;
    r_nxt.s1    = pins;
    r_nxt.s2    = r_r.s1;
    r_nxt.scl_q = r_r.s2.scl;
    r_nxt.sda_q = r_r.s2.sda;
    // Internally timed write cycle
    if (r_r.wtimer != '0)
      r_nxt.wtimer = r_r.wtimer - 1'b1;

    // Two-wire protocol engine
    if (!prog)
    begin
      r_nxt.st  = ST_IDLE;
      r_nxt.ack = 1'b0;
    end
    else if (start)
    begin
      // Repeated start also lands here
      r_nxt.st  = ST_DEV;
      r_nxt.cnt = '0;
      r_nxt.ack = 1'b0;
    end
    else if (stop)
    begin
      r_nxt.st  = ST_IDLE;
      r_nxt.ack = 1'b0;
      if (r_r.wrote)
        r_nxt.wtimer = TWR_CYC;
      r_nxt.wrote = 1'b0;
    end
    else if (r_r.st != ST_IDLE && rise)
    begin
      if (r_r.st == ST_RACK)
        r_nxt.hack = !r_r.s2.sda;
      else if (!r_r.ack)
      begin
        r_nxt.cnt = r_r.cnt + 1'b1;
        if (r_r.st == ST_WDAT)
          r_nxt.sh = {r_r.s2.sda, r_r.sh[7:1]};
        else if (r_r.st != ST_RDAT)
          r_nxt.sh = {r_r.sh[6:0], r_r.s2.sda};
      end
    end
    else if (r_r.st != ST_IDLE && fall)
    begin
      if (r_r.ack)
      begin
        // Acknowledge slot over: release and move on
        r_nxt.ack = 1'b0;
        r_nxt.cnt = '0;
        if (!r_r.ack_drv)
          r_nxt.st = ST_IDLE;
        else
          unique case (r_r.st)
            ST_DEV:
            begin
              r_nxt.st = r_r.sh[0] ? ST_RDAT : ST_AHI;
              r_nxt.tx = mem_rd_data_in;
            end
            ST_AHI:  r_nxt.st = ST_ALO;
            ST_ALO:  r_nxt.st = ST_WDAT;
            default: r_nxt.st = r_r.st;
          endcase
      end
      else if (r_r.st == ST_RDAT)
      begin
        if (r_r.cnt == BYTE_BITS)
        begin
          r_nxt.st   = ST_RACK;
          r_nxt.addr = r_r.addr + 1'b1;
        end
        else
          r_nxt.tx = {1'b0, r_r.tx[7:1]};
      end
      else if (r_r.st == ST_RACK)
      begin
        r_nxt.cnt = '0;
        r_nxt.st  = r_r.hack ? ST_RDAT : ST_IDLE;
        r_nxt.tx  = mem_rd_data_in;
      end
      else if (r_r.cnt == BYTE_BITS)
      begin
        // Byte received: decide acknowledge
        r_nxt.ack     = 1'b1;
        r_nxt.ack_drv = 1'b1;
        unique case (r_r.st)
          ST_DEV:  r_nxt.ack_drv = dev_ok;
          ST_AHI:  r_nxt.addr[14:8] = r_r.sh[6:0];
          ST_ALO:  r_nxt.addr[7:0]  = r_r.sh;
          ST_WDAT:
          begin
            r_nxt.ack_drv = push_ready;
            if (push_ready)
            begin
              push        = 1'b1;
              r_nxt.wrote = 1'b1;
              r_nxt.addr[PAGE_W-1:0] = r_r.addr[PAGE_W-1:0] + 1'b1;
              if (r_r.addr == POL_ADDR)
                r_nxt.pol_hi = (r_r.sh == POL_HI);
            end
          end
          default: r_nxt.ack_drv = 1'b0;
        endcase
      end
    end

    // Configuration stream when not programming
    if (prog || rst_act)
    begin
      r_nxt.caddr = '0;
      r_nxt.cbit  = '0;
      r_nxt.done  = 1'b0;
    end
    else if (ce_act && !r_r.done && rise)
    begin
      if (r_r.caddr == LAST_ADDR && r_r.cbit == LAST_BIT)
        r_nxt.done = 1'b1;
      else
      begin
        r_nxt.cbit = r_r.cbit + 1'b1;
        if (r_r.cbit == LAST_BIT)
          r_nxt.caddr = r_r.caddr + 1'b1;
      end
    end

    // Pin drivers, registered
    r_nxt.rdaddr = prog ? r_nxt.addr : r_nxt.caddr;
    if (prog)
    begin
      r_nxt.sda_o  = 1'b0;
      r_nxt.sda_oe = (r_nxt.ack && r_nxt.ack_drv) ||
                     (r_nxt.st == ST_RDAT && !r_nxt.ack &&
                      !r_nxt.tx[0]);
      r_nxt.ceo_o  = 1'b0;
      r_nxt.ceo_oe = 1'b0;
    end
    else
    begin
      r_nxt.sda_o  = mem_rd_data_in[r_r.cbit];
      r_nxt.sda_oe = ce_act && !rst_act && !r_nxt.done;
      r_nxt.ceo_o  = !r_nxt.done;
      r_nxt.ceo_oe = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      r_r <= '0;
    else
      r_r <= r_nxt;
  end

  // ------------------------------------------------------------
  // Write request buffer toward the array
  // ------------------------------------------------------------
  wr_fifo #(
    .W     ($bits(wr_req_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_wr_fifo (
    .clk_sys_in    (clk_sys_in),
    .arst_n_in     (arst_n_in),
    .in_valid_in   (push),
    .in_ready_out  (push_ready),
    .in_data_in    (wreq),
    .out_valid_out (fifo_busy),
    .out_ready_in  (mem_wr_ready_in),
    .out_data_out  (mem_wr_out)
  );

  // Outputs
  assign mem_wr_valid_out        = fifo_busy;
  assign sda_out                 = r_r.sda_o;
  assign sda_oe_out              = r_r.sda_oe;
  assign cascade_enable_out      = r_r.ceo_o;
  assign cascade_enable_oe_out   = r_r.ceo_oe;
  assign mem_rd_addr_out         = r_r.rdaddr;
  assign write_busy_out          = (r_r.wtimer != '0) || fifo_busy;
  assign reset_polarity_high_out = r_r.pol_hi;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!arst_n_in);

  sequence s_last_bit;
    !prog && !rst_act && ce_act && rise && !r_r.done &&
    r_r.caddr == LAST_ADDR && r_r.cbit == LAST_BIT;
  endsequence
  sequence s_hi_byte_end;
    prog && fall && !start && !stop && r_r.st == ST_AHI &&
    !r_r.ack && r_r.cnt == BYTE_BITS;
  endsequence

  property p_ceo_after_last;
    s_last_bit |=> !r_r.ceo_o && !r_r.sda_oe;
  endproperty
  a_ceo_after_last: assert property (p_ceo_after_last)
    else $error("cascade output not low after last bit");

  property p_ce_enables;
    !prog && ce_act && !rst_act && !r_r.done &&
    !(rise && r_r.caddr == LAST_ADDR && r_r.cbit == LAST_BIT)
    |=> r_r.sda_oe;
  endproperty
  a_ce_enables: assert property (p_ce_enables)
    else $error("data not driven with chip enable low");

  property p_standby;
    !prog && r_r.s2.ce_n |=> !r_r.sda_oe;
  endproperty
  a_standby: assert property (p_standby)
    else $error("data driven in standby");

  property p_polarity;
    !prog && (r_r.pol_hi == r_r.s2.roe) |=> r_r.caddr == '0;
  endproperty
  a_polarity: assert property (p_polarity)
    else $error("config counter not held in reset");

  property p_ignore_bus;
    r_r.s2.spe_n |=> r_r.st == ST_IDLE && !r_r.ack;
  endproperty
  a_ignore_bus: assert property (p_ignore_bus)
    else $error("bus traffic seen outside programming");

  property p_start;
    prog && start |=> r_r.st == ST_DEV && r_r.cnt == '0;
  endproperty
  a_start: assert property (p_start)
    else $error("start not recognised");

  property p_write_cycle;
    prog && stop && r_r.wrote |=> r_r.wtimer == TWR_CYC && !dev_ok;
  endproperty
  a_write_cycle: assert property (p_write_cycle)
    else $error("write cycle not started on stop");

  property p_page_wrap;
    push |=> r_r.addr[14:6] == $past(r_r.addr[14:6]) &&
      r_r.addr[5:0] == $past(r_r.addr[5:0]) + 6'h1;
  endproperty
  a_page_wrap: assert property (p_page_wrap)
    else $error("write address left its page");

  property p_addr_ack;
    s_hi_byte_end |=> r_r.sda_oe [*2] ##0
      r_r.addr[14:8] == $past(r_r.sh[6:0], 2);
  endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("address byte not acknowledged");

endmodule : serial_config_eeprom_prog_port

// file: verification/prog_master_model.sv
// Purpose: Programmer model for the two-wire port and the link clock
// Assumes: Data wire resolved in the bench with a pull-up
// Notes:   Open drain; clock phases eight and a half system cycles
`timescale 1ns/100ps
module prog_master_model #(
  parameter int Q = 170
) (
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_low_out
);
  // --------------------------------------------------------
  // Bus primitives
  // --------------------------------------------------------
  // Idle: clock high, data released
  initial
  begin
    scl_out     = 1'b1;
    sda_low_out = 1'b0;
  end

  // Start from idle or from clock low
  task automatic start();
    #(Q) sda_low_out = 1'b0;
    #(Q) scl_out = 1'b1;      // Clock rises, data released
    #(Q) sda_low_out = 1'b1;  // Data falls, clock high
    #(Q) scl_out = 1'b0;
  endtask : start

  // Stop from clock low
  task automatic stop();
    #(Q) sda_low_out = 1'b1;
    #(Q) scl_out = 1'b1;
    #(Q) sda_low_out = 1'b0;  // Data rises, clock high
    #(Q);
  endtask : stop

  // One bit slot, sampled in the middle of the high phase
  task automatic bit_slot(input logic b, output logic r);
    #(Q) sda_low_out = ~b;    // Pull low or release, clock low
    #(Q) scl_out = 1'b1;
    #(Q) r = sda_in;
    #(Q) scl_out = 1'b0;
  endtask : bit_slot

  // Byte out, then acknowledge slot
  task automatic wr_byte(input logic [7:0] v, input logic lsb_first,
                         output logic ack);
    logic r;
    for (int i = 0; i < 8; i++)
      bit_slot(lsb_first ? v[i] : v[7-i], r);
    bit_slot(1'b1, r);        // Released for the answer
    ack = ~r;
  endtask : wr_byte

  // Byte in, then our own acknowledge
  task automatic rd_byte(input logic give_ack, output logic [7:0] v);
    logic r;
    for (int i = 0; i < 8; i++)
    begin
      bit_slot(1'b1, r);
      v[i] = r;               // LSB first
    end
    bit_slot(~give_ack, r);   // Programmer answers read data
  endtask : rd_byte

  // One link clock rising edge in config mode
  task automatic cfg_pulse();
    scl_out = 1'b0;
    #(2*Q) scl_out = 1'b1;
    #(2*Q);
  endtask : cfg_pulse
endmodule : prog_master_model

// file: verification/test_serial_config_eeprom_prog_port.sv
// Purpose: Self-checking bench for the serial config EEPROM port
// Assumes: Programmer model on the wire, array model in this bench
// Notes:   Short write cycle and a four-byte config image
`timescale 1ns/100ps
module test_serial_config_eeprom_prog_port;
  import eeprom_prog_pkg::*;

  localparam int         D    = 1;  // Input delay after clock edge
  localparam logic [7:0] DEVW = {DEV_ID, 1'b0, DEV_FIX, 1'b0};

  logic       clk = 1'b0, arst_n = 1'b0, ce_n = 1'b0, reset_oe = 1'b1;
  logic       spe_n = 1'b0, casc_in = 1'b0, wr_ready = 1'b1;
  logic       scl, prg_low, sda_w, dut_sda, dut_oe, casc_out, casc_oe;
  logic       wr_valid, busy, pol_hi, ok;
  logic [7:0] rd_data = 8'h00, v;
  logic [14:0] rd_addr;
  wr_req_s    wr_req;
  logic [7:0] mem [0:32767];
  int         bad_count = 0, num_checks = 0;

  // --------------------------------------------------------
  // Clock, wire and array model
  // --------------------------------------------------------
  always #20 clk = ~clk;

  // Pull-up wins unless someone drives
  assign sda_w = prg_low ? 1'b0 : (dut_oe ? dut_sda : 1'b1);

  // Read one cycle after address; writes popped when ready
  always @(posedge clk)
  begin
    rd_data <= mem[rd_addr];
    if (wr_valid && wr_ready)
      mem[wr_req.addr] <= wr_req.data;
  end

  prog_master_model PRG (.sda_in(sda_w), .scl_out(scl),
                         .sda_low_out(prg_low));

  serial_config_eeprom_prog_port #(
    .TWR_CYC    (20'h0_01F4),
    .LAST_ADDR  (15'h0003),
    .FIFO_DEPTH (4)
  ) DUT (
    .clk_sys_in                 (clk),
    .arst_n_in                  (arst_n),
    .scl_in                     (scl),
    .sda_in                     (sda_w),
    .sda_out                    (dut_sda),
    .sda_oe_out                 (dut_oe),
    .ce_n_in                    (ce_n),
    .reset_oe_in                (reset_oe),
    .serial_program_enable_n_in (spe_n),
    .cascade_enable_in          (casc_in),
    .cascade_enable_out         (casc_out),
    .cascade_enable_oe_out      (casc_oe),
    .mem_rd_addr_out            (rd_addr),
    .mem_rd_data_in             (rd_data),
    .mem_wr_valid_out           (wr_valid),
    .mem_wr_ready_in            (wr_ready),
    .mem_wr_out                 (wr_req),
    .write_busy_out             (busy),
    .reset_polarity_high_out    (pol_hi)
  );

  // --------------------------------------------------------
  // Helpers
  // --------------------------------------------------------
  function automatic logic [7:0] pat(input int a);
    return 8'(a * 37 + 5);
  endfunction : pat

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wb(input logic [7:0] b, input logic lsb, input logic exp);
    logic a;
    PRG.wr_byte(b, lsb, a);
    check("ack", a, exp);
  endtask : wb

  task automatic addr_frame(input logic [14:0] a);
    PRG.start();
    wb(DEVW, 1'b0, 1'b1);
    wb({1'b0, a[14:8]}, 1'b0, 1'b1);
    wb(a[7:0], 1'b0, 1'b1);
  endtask : addr_frame

  task automatic wait_idle();
    for (int i = 0; i < 4000 && busy !== 1'b0; i++)
      @(posedge clk);
    check("busy", busy, 1'b0);
  endtask : wait_idle

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : conclude

  // --------------------------------------------------------
  // Tests
  // --------------------------------------------------------
  initial
  begin
    for (int i = 0; i < 32768; i++)
      mem[i] = pat(i);
    repeat (16) @(posedge clk);
    #(D) arst_n = 1'b1;
    repeat (10) @(posedge clk);
    check("polarity", pol_hi, 1'b0);
    PRG.start();
    wb(DEVW | 8'h08, 1'b0, 1'b0);
    PRG.stop();
    // Whole page from mid-page, wrapping inside it
    addr_frame(15'h013E);
    for (int i = 0; i < 64; i++)
      wb(8'(i) ^ 8'h5A, 1'b1, 1'b1);
    PRG.stop();
    repeat (8) @(posedge clk);
    check("busy", busy, 1'b1);
    PRG.start();
    wb(DEVW, 1'b0, 1'b0);
    ok = 1'b0;
    for (int i = 0; i < 12 && ok !== 1'b1; i++)
    begin
      PRG.start();
      PRG.wr_byte(DEVW, 1'b0, ok);
    end
    check("poll", ok, 1'b1);
    wb(8'h01, 1'b0, 1'b1);
    wb(8'h3E, 1'b0, 1'b1);
    PRG.start();
    wb(DEVW | 8'h01, 1'b0, 1'b1);
    for (int i = 0; i < 3; i++)
    begin
      PRG.rd_byte(i < 2, v);
      check("read", v, (i == 2) ? pat(320) : 8'(i) ^ 8'h5A);
    end
    PRG.stop();
    for (int i = 0; i < 64; i++)
      check("page", mem[256 + (62 + i) % 64], 8'(i) ^ 8'h5A);
    // Array stalls: fifth byte refused, then drained
    @(posedge clk);
    #(D) wr_ready = 1'b0;
    addr_frame(15'h0200);
    for (int i = 0; i < 5; i++)
      wb(8'(i), 1'b1, i < 4);
    PRG.stop();
    @(posedge clk);
    #(D) wr_ready = 1'b1;
    wait_idle();
    for (int i = 0; i < 4; i++)
      check("fifo", mem[512 + i], 8'(i));
    // Standby with program enable high
    @(posedge clk);
    #(D) spe_n = 1'b1;
    ce_n = 1'b1;
    PRG.start();
    wb(DEVW, 1'b0, 1'b0);
    PRG.stop();
    check("standby", dut_oe, 1'b0);
    // Config stream, cleared by reset/OE
    @(posedge clk);
    #(D) ce_n = 1'b0;
    reset_oe = 1'b0;
    repeat (8) @(posedge clk);
    check("reset", dut_oe, 1'b0);
    #(D) reset_oe = 1'b1;
    repeat (8) @(posedge clk);
    check("chain oe", casc_oe, 1'b1);
    for (int k = 0; k < 32; k++)
    begin
      check("stream", {dut_oe, dut_sda}, {1'b1, mem[k/8][k%8]});
      PRG.cfg_pulse();
      check("chain", casc_out, k < 31);
    end
    check("handoff", dut_oe, 1'b0);
    // Polarity option through the write path
    @(posedge clk);
    #(D) spe_n = 1'b0;
    repeat (8) @(posedge clk);
    addr_frame(15'h3FFF);
    wb(8'hFF, 1'b1, 1'b1);
    PRG.stop();
    wait_idle();
    check("polarity", pol_hi, 1'b1);
    conclude();
  end

  // Watchdog sized well past the expected run
  initial
  begin
    #(3_000_000);
    bad_count++;
    $display("Error watchdog: expected done seen hang");
    conclude();
  end
endmodule : test_serial_config_eeprom_prog_port
